// ===== snzc_ctrl.sv
// Purpose: Standby sequencer for normal, STOP and SNOOZE with APB registers
// Assumes: All inputs synchronous to core_clk; event inputs are one-cycle pulses
// Notes: Watchdog option straps are captured on the first edge after reset release
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps

module snzc_ctrl (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic standby_cmd,
	input wire logic interval_timer_request,
	input wire logic external_wake_irq,
	input wire logic xfer_done,
	input wire logic conversion_done_irq,
	input wire logic conv_wake_match,
	input wire logic uart_rx_start,
	input wire logic reset_req,
	input wire logic watchdog_enable_option,
	input wire logic watchdog_standby_option,
	output logic [1:0] mode,
	output logic fast_osc_en,
	output logic slow_osc_en,
	output logic wdt_osc_en,
	output logic wdt_counter_clr,
	output logic data_transfer_ctrl_start,
	output logic conv_start,
	output logic [7:0] snooze_state_pin,
	output logic uart_err_risk,
	output logic irq
);
	snzc_pkg::snzc_mode_t st_q, st_d;
	logic xfer_go_q, xfer_go_d;
	logic conv_act_q, conv_act_d;
	logic wake_prev_q;
	logic opt_done_q, opt_wdt_en_q, opt_wdt_stby_q;
	logic [7:0] ctrl_q, ctrl_d;
	logic [15:0] intv_q, intv_d, dly_q, dly_d, wid_q, wid_d, wait_q, wait_d;
	logic [snzc_pkg::EV_W-1:0] stat_q, stat_d, mask_q, mask_d, ev_set;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic fast_q, fast_d, wdt_q, wdt_d, clr_q, clr_d, dstart_q, dstart_d;
	logic cstart_q, cstart_d, uerr_q, uerr_d, irq_q, irq_d;
	logic [7:0] pin_q, pin_d;
	logic osc_start, osc_halt, osc_ready, pulse_high, delay_hit;
	logic wake_edge, wr_acc, rd_acc, addr_ok;

	function automatic logic known_addr(input logic [7:0] a);
		known_addr = (a == snzc_pkg::OFF_CTRL) || (a == snzc_pkg::OFF_STATUS) ||
			(a == snzc_pkg::OFF_IRQ_STAT) || (a == snzc_pkg::OFF_IRQ_MASK) ||
			(a == snzc_pkg::OFF_INTERVAL) || (a == snzc_pkg::OFF_DELAY) ||
			(a == snzc_pkg::OFF_WIDTH) || (a == snzc_pkg::OFF_OSC_WAIT);
	endfunction

	assign wake_edge = external_wake_irq & ~wake_prev_q;
	assign wr_acc = psel & penable & pready_q & pwrite;
	assign rd_acc = psel & penable & pready_q & ~pwrite;
	assign addr_ok = known_addr(paddr);

	// Standby state machine
	always_comb begin
		st_d = st_q;
		xfer_go_d = xfer_go_q;
		conv_act_d = conv_act_q;
		osc_start = 1'b0;
		osc_halt = 1'b0;
		dstart_d = 1'b0;
		cstart_d = 1'b0;
		clr_d = 1'b0;
		ev_set = '0;
		case (st_q)
			snzc_pkg::SNZC_NORMAL: begin
				// Snooze activation here is ignored: snooze only follows STOP
				if (standby_cmd) begin
					st_d = snzc_pkg::SNZC_STOP;
					osc_halt = 1'b1;
				end
			end
			snzc_pkg::SNZC_STOP: begin
				if (wake_edge) begin
					st_d = snzc_pkg::SNZC_NORMAL;
					ev_set[snzc_pkg::EV_WAKE] = 1'b1;
				end else if (interval_timer_request ||
						(ctrl_q[snzc_pkg::CTRL_CONV_MODE] && delay_hit)) begin
					st_d = snzc_pkg::SNZC_SNOOZE;
					osc_start = 1'b1;
					xfer_go_d = 1'b0;
					conv_act_d = ~interval_timer_request;
					ev_set[snzc_pkg::EV_SNOOZE] = 1'b1;
				end
			end
			snzc_pkg::SNZC_SNOOZE: begin
				if (wake_edge) begin
					st_d = snzc_pkg::SNZC_NORMAL;
					ev_set[snzc_pkg::EV_WAKE] = 1'b1;
				end else if (!xfer_go_q && osc_ready) begin
					// Transfer only once the fast oscillator has settled
					xfer_go_d = 1'b1;
					dstart_d = ~conv_act_q;
					cstart_d = conv_act_q;
				end else if (xfer_go_q && conv_act_q && conversion_done_irq) begin
					ev_set[snzc_pkg::EV_CONV] = 1'b1;
					if (conv_wake_match) begin
						st_d = snzc_pkg::SNZC_NORMAL;
						ev_set[snzc_pkg::EV_WAKE] = 1'b1;
					end else begin
						st_d = snzc_pkg::SNZC_STOP;
						osc_halt = 1'b1;
						ev_set[snzc_pkg::EV_RESTOP] = 1'b1;
					end
				end else if (xfer_go_q && !conv_act_q && xfer_done) begin
					st_d = snzc_pkg::SNZC_STOP;
					osc_halt = 1'b1;
					ev_set[snzc_pkg::EV_RESTOP] = 1'b1;
				end
			end
			default: st_d = snzc_pkg::SNZC_NORMAL;
		endcase
		if (st_q != snzc_pkg::SNZC_NORMAL && st_d == snzc_pkg::SNZC_NORMAL &&
				opt_wdt_en_q && !opt_wdt_stby_q)
			clr_d = 1'b1;
		if (reset_req) begin
			st_d = snzc_pkg::SNZC_NORMAL;
			osc_start = 1'b0;
			osc_halt = 1'b1;
			dstart_d = 1'b0;
			cstart_d = 1'b0;
		end
		// Reception while the wake bit is set but outside a clean STOP window
		uerr_d = uart_rx_start && ctrl_q[snzc_pkg::CTRL_UWC] &&
			((st_q == snzc_pkg::SNZC_NORMAL) || (st_q == snzc_pkg::SNZC_SNOOZE));
		ev_set[snzc_pkg::EV_UART_ERR] = uerr_d;
	end

	// Oscillator enables and status pins
	always_comb begin
		fast_d = (st_d != snzc_pkg::SNZC_STOP);
		// Watchdog oscillator runs in standby only with both options set
		wdt_d = opt_wdt_en_q && ((st_d == snzc_pkg::SNZC_NORMAL) || opt_wdt_stby_q);
		pin_d = 8'h00;
		if (ctrl_q[snzc_pkg::CTRL_STAT_EN] && pulse_high && (st_q == snzc_pkg::SNZC_SNOOZE))
			pin_d[ctrl_q[snzc_pkg::CTRL_PIN_SEL_HI:snzc_pkg::CTRL_PIN_SEL_LO]] = 1'b1;
	end

	// APB register file; status set wins over read clear
	always_comb begin
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		intv_d = intv_q;
		dly_d = dly_q;
		wid_d = wid_q;
		wait_d = wait_q;
		prdata_d = prdata_q;
		pready_d = psel & ~penable;
		pslverr_d = psel & ~penable & ~addr_ok;
		stat_d = stat_q;
		// Clear only the bits the setup cycle captured, so an event landing then is kept
		if (rd_acc && paddr == snzc_pkg::OFF_IRQ_STAT)
			stat_d = stat_q & ~prdata_q[snzc_pkg::EV_W-1:0];
		stat_d = stat_d | ev_set;
		if (psel && !penable && !pwrite) begin
			prdata_d = 32'h00000000;
			if (paddr == snzc_pkg::OFF_CTRL)
				prdata_d[7:0] = ctrl_q;
			else if (paddr == snzc_pkg::OFF_STATUS)
				prdata_d[7:0] = {fast_q, wdt_q, osc_ready, opt_wdt_stby_q, opt_wdt_en_q,
					xfer_go_q, 2'(st_q)};
			else if (paddr == snzc_pkg::OFF_IRQ_STAT)
				prdata_d[snzc_pkg::EV_W-1:0] = stat_q;
			else if (paddr == snzc_pkg::OFF_IRQ_MASK)
				prdata_d[snzc_pkg::EV_W-1:0] = mask_q;
			else if (paddr == snzc_pkg::OFF_INTERVAL)
				prdata_d[15:0] = intv_q;
			else if (paddr == snzc_pkg::OFF_DELAY)
				prdata_d[15:0] = dly_q;
			else if (paddr == snzc_pkg::OFF_WIDTH)
				prdata_d[15:0] = wid_q;
			else if (paddr == snzc_pkg::OFF_OSC_WAIT)
				prdata_d[15:0] = wait_q;
		end
		if (wr_acc) begin
			if (paddr == snzc_pkg::OFF_CTRL)
				ctrl_d = pwdata[7:0];
			else if (paddr == snzc_pkg::OFF_IRQ_MASK)
				mask_d = pwdata[snzc_pkg::EV_W-1:0];
			else if (paddr == snzc_pkg::OFF_INTERVAL)
				intv_d = pwdata[15:0];
			else if (paddr == snzc_pkg::OFF_DELAY)
				dly_d = pwdata[15:0];
			else if (paddr == snzc_pkg::OFF_WIDTH)
				wid_d = pwdata[15:0];
			else if (paddr == snzc_pkg::OFF_OSC_WAIT)
				wait_d = pwdata[15:0];
		end
		irq_d = |(stat_d & mask_q);
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= snzc_pkg::SNZC_NORMAL;
			xfer_go_q <= 1'b0;
			conv_act_q <= 1'b0;
			wake_prev_q <= 1'b0;
			ctrl_q <= 8'h00;
			mask_q <= '0;
			stat_q <= '0;
			intv_q <= snzc_pkg::INTERVAL_RST;
			dly_q <= snzc_pkg::DELAY_RST;
			wid_q <= snzc_pkg::WIDTH_RST;
			wait_q <= snzc_pkg::OSC_WAIT_CYC;
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			fast_q <= 1'b1;
			wdt_q <= 1'b0;
			clr_q <= 1'b0;
			dstart_q <= 1'b0;
			cstart_q <= 1'b0;
			uerr_q <= 1'b0;
			irq_q <= 1'b0;
			pin_q <= 8'h00;
		end else begin
			st_q <= st_d;
			xfer_go_q <= xfer_go_d;
			conv_act_q <= conv_act_d;
			wake_prev_q <= external_wake_irq;
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			stat_q <= stat_d;
			intv_q <= intv_d;
			dly_q <= dly_d;
			wid_q <= wid_d;
			wait_q <= wait_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			fast_q <= fast_d;
			wdt_q <= wdt_d;
			clr_q <= clr_d;
			dstart_q <= dstart_d;
			cstart_q <= cstart_d;
			uerr_q <= uerr_d;
			irq_q <= irq_d;
			pin_q <= pin_d;
		end
	end

	// Option straps are captured once, after reset release, never under reset
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			opt_done_q <= 1'b0;
			opt_wdt_en_q <= 1'b0;
			opt_wdt_stby_q <= 1'b0;
		end else if (!opt_done_q) begin
			opt_done_q <= 1'b1;
			opt_wdt_en_q <= watchdog_enable_option;
			opt_wdt_stby_q <= watchdog_standby_option;
		end
	end

	snzc_osc_wait u_osc_wait (
		.core_clk(core_clk),
		.resetn(resetn),
		.start(osc_start),
		.halt(osc_halt),
		.wait_cyc(wait_q),
		.ready(osc_ready)
	);

	// Timer runs outside normal mode so it can also release STOP
	snzc_status_timer u_status_timer (
		.core_clk(core_clk),
		.resetn(resetn),
		.enable(st_q != snzc_pkg::SNZC_NORMAL),
		.status_interval_compare(intv_q),
		.cpu_irq_delay_compare(dly_q),
		.status_pulse_width_compare(wid_q),
		.pulse_high(pulse_high),
		.delay_hit(delay_hit)
	);

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign mode = 2'(st_q);
	assign fast_osc_en = fast_q;
	assign slow_osc_en = 1'b1; // Slow oscillator never stops in any mode
	assign wdt_osc_en = wdt_q;
	assign wdt_counter_clr = clr_q;
	assign data_transfer_ctrl_start = dstart_q;
	assign conv_start = cstart_q;
	assign snooze_state_pin = pin_q;
	assign uart_err_risk = uerr_q;
	assign irq = irq_q;
endmodule

// ===== snzc_pkg.sv
// Purpose: Shared constants for the snooze mode controller
// Assumes: APB with 32-bit data, 100 MHz core clock
// Notes: Offsets are byte addresses
package snzc_pkg;
	typedef enum logic [1:0] {
		SNZC_NORMAL,
		SNZC_STOP,
		SNZC_SNOOZE
	} snzc_mode_t;

	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
	localparam logic [7:0] OFF_INTERVAL = 8'h10;
	localparam logic [7:0] OFF_DELAY = 8'h14;
	localparam logic [7:0] OFF_WIDTH = 8'h18;
	localparam logic [7:0] OFF_OSC_WAIT = 8'h1c;

	// Control register fields
	localparam int CTRL_UWC = 0;
	localparam int CTRL_STAT_EN = 1;
	localparam int CTRL_CONV_MODE = 2;
	localparam int CTRL_PIN_SEL_LO = 4;
	localparam int CTRL_PIN_SEL_HI = 6;

	// Event bits, shared by status and mask
	localparam int EV_SNOOZE = 0;
	localparam int EV_RESTOP = 1;
	localparam int EV_WAKE = 2;
	localparam int EV_UART_ERR = 3;
	localparam int EV_CONV = 4;
	localparam int EV_W = 5;

	localparam logic [15:0] INTERVAL_RST = 16'h03e8;
	localparam logic [15:0] DELAY_RST = 16'h0064;
	localparam logic [15:0] WIDTH_RST = 16'h000a;

	localparam int CLK_PERIOD_NS = 10;
	localparam int OSC_WAIT_NS = 1000;
	localparam logic [15:0] OSC_WAIT_CYC = 16'((OSC_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// ===== snzc_osc_wait.sv
// Purpose: Counts the fast oscillator settling time after restart
// Assumes: start is a one-cycle pulse
// Notes: ready stays high until the oscillator is halted or started again
`timescale 1ns/100ps
module snzc_osc_wait (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic halt,
	input wire logic [15:0] wait_cyc,
	output logic ready
);
	logic [15:0] cnt_q, cnt_d;
	logic busy_q, busy_d;
	logic ready_q, ready_d;

	always_comb begin
		cnt_d = cnt_q;
		busy_d = busy_q;
		ready_d = ready_q;
		if (halt) begin
			busy_d = 1'b0;
			ready_d = 1'b0;
		end else if (start) begin
			cnt_d = (wait_cyc == 16'h0000) ? 16'h0001 : wait_cyc;
			busy_d = 1'b1;
			ready_d = 1'b0;
		end else if (busy_q) begin
			cnt_d = cnt_q - 16'h0001;
			if (cnt_q == 16'h0001) begin
				busy_d = 1'b0;
				ready_d = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 16'h0000;
			busy_q <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			ready_q <= ready_d;
		end
	end

	assign ready = ready_q;
endmodule

// ===== snzc_status_timer.sv
// Purpose: Compare timer that paces the snooze status pulse and CPU request
// Assumes: Compare values are stable while enabled
// Notes: Counter wraps at the interval value
`timescale 1ns/100ps
module snzc_status_timer (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic enable,
	input wire logic [15:0] status_interval_compare,
	input wire logic [15:0] cpu_irq_delay_compare,
	input wire logic [15:0] status_pulse_width_compare,
	output logic pulse_high,
	output logic delay_hit
);
	logic [15:0] cnt_q, cnt_d;
	logic high_q, high_d;
	logic hit_q, hit_d;

	always_comb begin
		cnt_d = 16'h0000;
		high_d = 1'b0;
		hit_d = 1'b0;
		if (enable) begin
			cnt_d = (cnt_q >= status_interval_compare) ? 16'h0000 : cnt_q + 16'h0001;
			high_d = (cnt_d < status_pulse_width_compare);
			hit_d = (cnt_d == cpu_irq_delay_compare);
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 16'h0000;
			high_q <= 1'b0;
			hit_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			high_q <= high_d;
			hit_q <= hit_d;
		end
	end

	assign pulse_high = high_q;
	assign delay_hit = hit_q;
endmodule

// ===== snzc_ctrl_assertions.sv
// Purpose: Port checker for the standby sequencer
// Assumes: One clock domain, async active-low reset
// Notes: Bound from the testbench top file
`timescale 1ns/100ps
module snzc_ctrl_assertions (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic standby_cmd,
	input wire logic interval_timer_request,
	input wire logic external_wake_irq,
	input wire logic reset_req,
	input wire logic watchdog_enable_option,
	input wire logic watchdog_standby_option,
	input wire logic [1:0] mode,
	input wire logic fast_osc_en,
	input wire logic slow_osc_en,
	input wire logic wdt_osc_en,
	input wire logic wdt_counter_clr,
	input wire logic data_transfer_ctrl_start
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence s_stop;
		mode == 2'd1 && !fast_osc_en;
	endsequence
	sequence s_snooze;
		mode == 2'd2 && fast_osc_en;
	endsequence
	a_stop_entry: assert property (mode == 2'd0 && standby_cmd && !reset_req |=> s_stop)
		else $error("stop entry wrong");
	a_snooze_entry: assert property (mode == 2'd1 && interval_timer_request && !reset_req
		&& !$rose(external_wake_irq) |=> s_snooze) else $error("snooze entry wrong");
	a_wake_first: assert property (mode != 2'd0 && $rose(external_wake_irq) && !reset_req
		|=> mode == 2'd0) else $error("wake did not reach normal");
	a_sync_reset: assert property (reset_req |=> mode == 2'd0)
		else $error("reset request ignored");
	a_no_direct: assert property (mode == 2'd0 |=> mode != 2'd2)
		else $error("snooze entered from normal");
	a_osc_state: assert property (fast_osc_en == (mode != 2'd1) && slow_osc_en)
		else $error("oscillator enables wrong");
	a_xfer_wait: assert property (data_transfer_ctrl_start |->
		mode == 2'd2 && $past(mode, 3) == 2'd2 ##1 !data_transfer_ctrl_start)
		else $error("transfer start too early");
	a_wdt_keep: assert property (watchdog_enable_option && watchdog_standby_option
		&& mode == 2'd1 && $past(mode) == 2'd1 |-> wdt_osc_en) else $error("wdt osc stopped");
	a_wdt_halt: assert property (watchdog_enable_option && !watchdog_standby_option
		&& mode == 2'd1 && $past(mode) == 2'd1 |-> !wdt_osc_en) else $error("wdt osc running");
	a_wdt_clear: assert property ($past(mode) != 2'd0 && mode == 2'd0 && !$past(reset_req)
		&& watchdog_enable_option && !watchdog_standby_option |-> wdt_counter_clr)
		else $error("wdt counter not cleared");
endmodule

// ===== snzc_periph_model.sv
// Purpose: Peripheral stand-in answering transfer and conversion starts
// Assumes: Starts are one-cycle pulses, one job at a time
// Notes: Answer delay comes from dly, so it can be prompt or slow
`timescale 1ns/100ps
module snzc_periph_model (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic data_transfer_ctrl_start,
	input wire logic conv_start,
	input wire logic match,
	input wire logic [7:0] dly,
	output logic xfer_done,
	output logic conversion_done_irq,
	output logic conv_wake_match
);
	logic busy_q, busy_d, conv_q, conv_d, tog_q, tog_d, fire;
	logic [7:0] cnt_q, cnt_d;
	assign fire = busy_q && cnt_q == 8'h00;
	assign xfer_done = fire && !conv_q;
	assign conversion_done_irq = fire && conv_q;
	// Toggles when idle so a stale result never looks valid
	assign conv_wake_match = conversion_done_irq ? match : tog_q;
	always_comb begin
		busy_d = busy_q && !fire;
		conv_d = conv_q;
		cnt_d = busy_q ? cnt_q - 8'h01 : cnt_q;
		tog_d = ~tog_q;
		if (data_transfer_ctrl_start || conv_start) begin
			busy_d = 1'b1;
			conv_d = conv_start;
			cnt_d = dly;
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			busy_q <= 1'b0;
			conv_q <= 1'b0;
			tog_q <= 1'b0;
			cnt_q <= 8'h00;
		end else begin
			busy_q <= busy_d;
			conv_q <= conv_d;
			tog_q <= tog_d;
			cnt_q <= cnt_d;
		end
	end
endmodule

// ===== snzc_ctrl_tb.sv
// Purpose: Self-checking bench for the standby sequencer
// Assumes: Straps change only while resetn is low
// Notes: Oscillator wait shortened to 2 cycles over APB
`timescale 1ns/100ps
module snzc_ctrl_tb;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, external_wake_irq = 1'b0, match = 1'b0;
	logic watchdog_enable_option = 1'b1, watchdog_standby_option = 1'b0, err;
	logic [7:0] paddr = 8'h00, dly = 8'h03, snooze_state_pin;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] ev = 4'h0;
	logic standby_cmd, interval_timer_request, uart_rx_start, reset_req, pready, pslverr;
	logic xfer_done, conversion_done_irq, conv_wake_match, fast_osc_en, slow_osc_en, irq;
	logic wdt_osc_en, wdt_counter_clr, data_transfer_ctrl_start, conv_start, uart_err_risk;
	logic [1:0] mode;
	int errors = 0, n_checks = 0, n_dstart = 0, n_clr = 0, pin_hi = 0, pin_bad = 0, h0;
	int n_cst = 0, n_uerr = 0;
	assign standby_cmd = ev[0];
	assign interval_timer_request = ev[1];
	assign uart_rx_start = ev[2];
	assign reset_req = ev[3];
	always #5 core_clk = ~core_clk;
	snzc_ctrl snzc_ctrl_inst (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .standby_cmd, .interval_timer_request, .external_wake_irq,
		.xfer_done, .conversion_done_irq, .conv_wake_match, .uart_rx_start, .reset_req,
		.watchdog_enable_option, .watchdog_standby_option, .mode, .fast_osc_en, .slow_osc_en,
		.wdt_osc_en, .wdt_counter_clr, .data_transfer_ctrl_start, .conv_start,
		.snooze_state_pin, .uart_err_risk, .irq);
	snzc_periph_model snzc_periph_model_inst (.core_clk, .resetn, .data_transfer_ctrl_start,
		.conv_start, .match, .dly, .xfer_done, .conversion_done_irq, .conv_wake_match);
	always @(posedge core_clk) begin
		if (data_transfer_ctrl_start === 1'b1)
			n_dstart <= n_dstart + 1;
		if (wdt_counter_clr === 1'b1)
			n_clr <= n_clr + 1;
		if (conv_start === 1'b1)
			n_cst <= n_cst + 1;
		if (uart_err_risk === 1'b1)
			n_uerr <= n_uerr + 1;
		if (snooze_state_pin[3] === 1'b1)
			pin_hi <= pin_hi + 1;
		if ((snooze_state_pin & 8'hf7) !== 8'h00)
			pin_bad <= pin_bad + 1;
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the slave
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic pulse(input int i);
		ev[i] <= 1'b1;
		@(posedge core_clk);
		ev[i] <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wt(input logic [1:0] m);
		int n;
		n = 0;
		while (mode !== m && n < 300) begin
			@(posedge core_clk);
			n++;
		end
		chk("mode", 32'(m), 32'(mode));
	endtask
	task automatic t_regs();
		logic [15:0] e [4] = '{snzc_pkg::INTERVAL_RST, snzc_pkg::DELAY_RST,
			snzc_pkg::WIDTH_RST, snzc_pkg::OSC_WAIT_CYC};
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, snzc_pkg::OFF_INTERVAL + 8'(4 * i), 32'h0);
			chk("reset value", 32'(e[i]), rd);
		end
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped read", 32'h0, rd);
		chk("unmapped err", 32'h1, 32'(err));
		apb(1'b1, snzc_pkg::OFF_OSC_WAIT, 32'h2);
		apb(1'b1, snzc_pkg::OFF_IRQ_MASK, 32'h1f);
		apb(1'b0, snzc_pkg::OFF_IRQ_STAT, 32'h0);
	endtask
	task automatic t_dtc();
		pulse(0);
		wt(2'd1);
		pulse(1);
		wt(2'd2);
		wt(2'd1);
		chk("transfer starts", 32'h1, 32'(n_dstart));
		cyc(2);
		chk("irq", 32'h1, 32'(irq));
		apb(1'b0, snzc_pkg::OFF_IRQ_STAT, 32'h0);
		chk("irq status", 32'h3, rd);
		external_wake_irq <= 1'b1;
		wt(2'd0);
		cyc(2);
		chk("wdt clear", 32'h1, 32'(n_clr));
		external_wake_irq <= 1'b0;
		apb(1'b0, snzc_pkg::OFF_IRQ_STAT, 32'h0);
		chk("wake status", 32'h4, rd);
		chk("irq cleared", 32'h0, 32'(irq));
	endtask
	task automatic t_prio();
		pulse(1);
		cyc(2);
		chk("mode", 32'h0, 32'(mode));
		pulse(0);
		wt(2'd1);
		ev[1] <= 1'b1;
		external_wake_irq <= 1'b1;
		@(posedge core_clk);
		ev[1] <= 1'b0;
		cyc(3);
		chk("mode", 32'h0, 32'(mode));
		external_wake_irq <= 1'b0;
	endtask
	task automatic t_status();
		apb(1'b1, snzc_pkg::OFF_INTERVAL, 32'h8);
		apb(1'b1, snzc_pkg::OFF_WIDTH, 32'h3);
		apb(1'b1, snzc_pkg::OFF_CTRL, 32'h32);
		dly <= 8'd60;
		pulse(0);
		pulse(1);
		wt(2'd2);
		h0 = pin_hi;
		cyc(30);
		chk("pin pulses", 32'h1, 32'(pin_hi - h0 >= 9 && pin_hi - h0 <= 12));
		chk("other pins", 32'h0, 32'(pin_bad));
		pulse(3);
		wt(2'd0);
		cyc(2);
		chk("pins idle", 32'h0, 32'(snooze_state_pin));
		apb(1'b1, snzc_pkg::OFF_CTRL, 32'h0);
		cyc(60);
	endtask
	task automatic t_conv();
		apb(1'b1, snzc_pkg::OFF_INTERVAL, 32'h14);
		apb(1'b1, snzc_pkg::OFF_DELAY, 32'h4);
		apb(1'b1, snzc_pkg::OFF_CTRL, 32'h4);
		dly <= 8'h03;
		pulse(0);
		wt(2'd2);
		wt(2'd1);
		match <= 1'b1;
		wt(2'd0);
		chk("conv starts", 32'h2, 32'(n_cst));
		apb(1'b0, snzc_pkg::OFF_IRQ_STAT, 32'h0);
		chk("conv event", 32'h1, 32'(rd[4]));
		apb(1'b1, snzc_pkg::OFF_CTRL, 32'h0);
	endtask
	task automatic t_uart();
		apb(1'b1, snzc_pkg::OFF_IRQ_MASK, 32'h0);
		apb(1'b1, snzc_pkg::OFF_CTRL, 32'h1);
		pulse(2);
		cyc(2);
		chk("uart risk pulse", 32'h1, 32'(n_uerr));
		chk("masked irq", 32'h0, 32'(irq));
		apb(1'b1, snzc_pkg::OFF_IRQ_MASK, 32'h8);
		cyc(2);
		chk("unmasked irq", 32'h1, 32'(irq));
		apb(1'b0, snzc_pkg::OFF_IRQ_STAT, 32'h0);
		chk("uart risk", 32'h8, rd);
		cyc(2);
		chk("irq after read", 32'h0, 32'(irq));
		apb(1'b1, snzc_pkg::OFF_CTRL, 32'h0);
		pulse(2);
		cyc(2);
		apb(1'b0, snzc_pkg::OFF_IRQ_STAT, 32'h0);
		chk("no uart risk", 32'h0, rd);
		chk("uart risk pulses", 32'h1, 32'(n_uerr));
	endtask
	task automatic t_wdt();
		pulse(0);
		wt(2'd1);
		cyc(2);
		chk("wdt osc", 32'h0, 32'(wdt_osc_en));
		resetn <= 1'b0;
		watchdog_standby_option <= 1'b1;
		cyc(1);
		chk("mode", 32'h0, 32'(mode));
		cyc(3);
		resetn <= 1'b1;
		cyc(2);
		apb(1'b0, snzc_pkg::OFF_STATUS, 32'h0);
		chk("options", 32'h3, 32'(rd[4:3]));
		pulse(0);
		wt(2'd1);
		cyc(2);
		chk("wdt osc", 32'h1, 32'(wdt_osc_en));
		external_wake_irq <= 1'b1;
		wt(2'd0);
	endtask
	task automatic end_of_test();
		if (errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		cyc(8);
		resetn <= 1'b1;
		cyc(2);
		t_regs();
		t_dtc();
		t_prio();
		t_status();
		t_conv();
		t_uart();
		t_wdt();
		end_of_test();
	end
	initial begin
		cyc(20000);
		errors++;
		end_of_test();
	end
endmodule
bind snzc_ctrl snzc_ctrl_assertions snzc_ctrl_assertions_inst (.core_clk, .resetn, .standby_cmd,
	.interval_timer_request, .external_wake_irq, .reset_req, .watchdog_enable_option,
	.watchdog_standby_option, .mode, .fast_osc_en, .slow_osc_en, .wdt_osc_en, .wdt_counter_clr,
	.data_transfer_ctrl_start);
